// ---- isv_defs.svh ----
// isv_defs.svh: offsets, field positions, vectors and reset values of the
// interrupt source and vector logic.
// assumes: included by bare name by the design module isv_top only.
`ifndef ISV_DEFS_SVH
`define ISV_DEFS_SVH

// ****************************************************************
// register byte offsets on the AHB-Lite slave
// ****************************************************************
`define ISV_OFS_CTRL 8'h00
`define ISV_OFS_TBASE 8'h04
`define ISV_OFS_AMATCH 8'h08
`define ISV_OFS_REQ 8'h0c
`define ISV_OFS_LEVEL 8'h10
`define ISV_OFS_STAT 8'h14

// ****************************************************************
// control register fields
// ****************************************************************
`define ISV_CTL_GIE 0
`define ISV_CTL_IPL_LO 1
`define ISV_CTL_IPL_HI 3
`define ISV_CTL_DSTEP 4
`define ISV_CTL_AMEN 5
`define ISV_CTL_USTK 6
`define ISV_CTL_OVF 7
`define ISV_CTL_EDA_LO 8
`define ISV_CTL_EDB_LO 10
`define ISV_CTL_RST 32'h0000_0000

// ****************************************************************
// fixed vector entries (20-bit address space)
// ****************************************************************
`define ISV_VEC_UND 20'hfffdc
`define ISV_VEC_OVF 20'hfffe0
`define ISV_VEC_BRK 20'hfffe4
`define ISV_VEC_AMATCH 20'hfffe8
`define ISV_VEC_STEP 20'hfffec
`define ISV_VEC_WDT 20'hffff0
`define ISV_VEC_DBC 20'hffff4
`define ISV_VEC_RESET 20'hffffc
`define ISV_VEC_ERASED 32'hffff_ffff
`define ISV_TBASE_RST 20'h00000

// ****************************************************************
// request bit positions of on-chip and external pin sources in the request register
// ****************************************************************
`define ISV_REQ_DISP_A 4
`define ISV_REQ_DISP_B 8
`define ISV_REQ_I2C1 9
`define ISV_REQ_I2C0 13
`define ISV_REQ_VSYNC 20
`define ISV_REQ_PIN_A 29
`define ISV_REQ_PIN_B 30

// ****************************************************************
// pending special/software event positions
// ****************************************************************
`define ISV_P_UND 0
`define ISV_P_OVF 1
`define ISV_P_BRK 2
`define ISV_P_SWI 3
`define ISV_P_WDT 4
`define ISV_P_DBC 5
`define ISV_P_STEP 6
`define ISV_P_AM 7
`define ISV_SWI_SPLIT 6'h20
`define ISV_EDGE_BOTH 2'h3

`endif

// ---- isv_pkg.sv ----
// isv_pkg.sv: types shared by the interrupt source and vector logic.
// assumes: isv_defs.svh is on the include path.
package isv_pkg;
  // instruction class reported by the core when an instruction retires
  typedef enum logic [2:0] {
    ISV_INSN_NONE  = 3'b000,
    ISV_INSN_ARITH = 3'b001,
    ISV_INSN_UND   = 3'b010,
    ISV_INSN_INTO  = 3'b011,
    ISV_INSN_BRK   = 3'b100,
    ISV_INSN_INT   = 3'b101,
    ISV_INSN_RETI  = 3'b110,
    ISV_INSN_OTHER = 3'b111
  } isv_insn_t;

  // vector fetch sequencer
  typedef enum logic {
    ISV_ST_IDLE  = 1'b0,
    ISV_ST_FETCH = 1'b1
  } isv_state_t;

  // cause of the interrupt being vectored
  typedef enum logic [3:0] {
    ISV_C_RESET  = 4'h0,
    ISV_C_DBC    = 4'h1,
    ISV_C_WDT    = 4'h2,
    ISV_C_STEP   = 4'h3,
    ISV_C_AMATCH = 4'h4,
    ISV_C_UND    = 4'h5,
    ISV_C_OVF    = 4'h6,
    ISV_C_BRK    = 4'h7,
    ISV_C_SWI    = 4'h8,
    ISV_C_PERIPH = 4'h9
  } isv_cause_t;
endpackage : isv_pkg

// ---- isv_pin_if.sv ----
// isv_pin_if.sv: raw pins, edge modes and request pulses between the
// main block and the pin edge detector.
// assumes: one clock domain, hclk.
`timescale 1ns/100ps
interface isv_pin_if #(parameter int N = 3);
  logic [N-1:0] pin;     // raw asynchronous pin levels
  logic [2*N-1:0] mode;  // per pin: bit0 rising, bit1 falling
  logic [N-1:0] hit;     // one-cycle request pulse per pin
  modport det (input pin, input mode, output hit);
  modport ctl (output pin, output mode, input hit);
endinterface : isv_pin_if

// ---- isv_pin_edge.sv ----
// isv_pin_edge.sv: synchronises external pins and turns selected edges
// into one-cycle request pulses.
// assumes: pins are asynchronous to hclk; modes come from hclk logic.
`timescale 1ns/100ps
module isv_pin_edge import isv_pkg::*; #(
  parameter int N = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  isv_pin_if.det pins
);

  logic [N-1:0] meta_q; // first stage, read only by sync_q
  logic [N-1:0] sync_q; // second stage
  logic [N-1:0] last_q; // previous synchronised level

  // ****************************************************************
  // two-flop synchroniser, then a history flop for edge detection
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= pins.pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // per pin: rising, falling or both edges as selected
  for (genvar i = 0; i < N; i++) begin : g_edge
    wire rise = sync_q[i] & ~last_q[i];
    wire fall = ~sync_q[i] & last_q[i];
    assign pins.hit[i] = (rise & pins.mode[2*i]) | (fall & pins.mode[2*i+1]);
  end
endmodule : isv_pin_edge

// ---- isv_top.sv ----
// isv_top.sv: interrupt source classification and vector resolution,
// with an AHB-Lite register slave.
// assumes: the core reports each retired instruction, holds off while
// irq_busy is high, and serves vector reads on the vec_rd port.
//
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "isv_defs.svh"

module isv_top
  import isv_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic insn_done,
  input wire isv_insn_t insn_kind,
  input wire logic [5:0] insn_operand,
  input wire logic arith_ovf,
  input wire logic fetch_valid,
  input wire logic [19:0] fetch_addr,
  input wire logic [31:0] periph_req,
  input wire logic wdt_req,
  input wire logic debugger_break_interrupt,
  input wire logic external_irq_pin_a,
  input wire logic external_irq_pin_b,
  input wire logic vsync_pin,
  input wire logic display_done_irq_a,
  input wire logic display_done_irq_b,
  input wire logic i2c0_event,
  input wire logic i2c1_event,
  output logic vec_rd_req,
  output logic [19:0] vec_rd_addr,
  input wire logic vec_rd_valid,
  input wire logic [31:0] vec_rd_data,
  output logic branch_valid,
  output logic [19:0] branch_addr,
  output logic irq_busy,
  output logic stack_select
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [31:0] ctrl_q;      // enable, level, step, match enable, edges
  logic [19:0] tbase_q;     // relocatable table base
  logic [19:0] amatch_q;    // programmed match address
  logic [31:0] req_q;       // request bits of table sources 0..31
  logic [2:0] level_q;      // common priority level of peripheral sources
  logic ovf_q;              // arithmetic overflow flag
  logic ustk_q;             // stack select: 0 interrupt stack pointer
  logic usave_q;            // stack select saved at acceptance
  logic [7:0] pend_q;       // pending special and software events
  logic [5:0] swi_num_q;    // operand of the pending software interrupt
  isv_state_t state_q;      // fetch sequencer
  isv_cause_t cause_q;      // cause being vectored
  logic [5:0] num_q;        // table number being vectored
  logic brk_fb_q;           // breakpoint already fell back to table
  logic [19:0] vaddr_q;     // vector entry address being read
  logic bvalid_q;           // branch pulse
  logic [19:0] baddr_q;     // branch target
  logic [31:0] stat_q;      // last branch, number and cause
  logic [31:0] rdata_q;     // bus read data
  logic dph_wr_q;           // write data phase pending
  logic [7:0] dph_ofs_q;    // offset of the pending write

  // ****************************************************************
  // bus decode: zero wait, always OKAY, only word accesses act
  // ****************************************************************
  wire ap_ok = hsel & htrans[1] & hready & (hsize == 3'h2);
  wire [7:0] ap_ofs = haddr[7:0];
  wire wr_ctrl = dph_wr_q & (dph_ofs_q == `ISV_OFS_CTRL);
  wire wr_tbase = dph_wr_q & (dph_ofs_q == `ISV_OFS_TBASE);
  wire wr_amatch = dph_wr_q & (dph_ofs_q == `ISV_OFS_AMATCH);
  wire wr_req = dph_wr_q & (dph_ofs_q == `ISV_OFS_REQ);
  wire wr_level = dph_wr_q & (dph_ofs_q == `ISV_OFS_LEVEL);
  wire gie = ctrl_q[`ISV_CTL_GIE];
  wire [2:0] ipl = ctrl_q[`ISV_CTL_IPL_HI:`ISV_CTL_IPL_LO];

  // read mux; an unmapped offset reads zero
  wire [31:0] ctrl_view = {ctrl_q[31:8], ovf_q, ustk_q, ctrl_q[5:0]};
  wire [31:0] rd_mux =
    (ap_ofs == `ISV_OFS_CTRL)   ? ctrl_view :
    (ap_ofs == `ISV_OFS_TBASE)  ? {12'h000, tbase_q} :
    (ap_ofs == `ISV_OFS_AMATCH) ? {12'h000, amatch_q} :
    (ap_ofs == `ISV_OFS_REQ)    ? req_q :
    (ap_ofs == `ISV_OFS_LEVEL)  ? {29'h0000000, level_q} :
    (ap_ofs == `ISV_OFS_STAT)   ? stat_q : 32'h0000_0000;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // ****************************************************************
  // external pins: pin a, pin b, vertical sync
  // ****************************************************************
  isv_pin_if #(.N(3)) pin_bus ();
  assign pin_bus.pin = {vsync_pin, external_irq_pin_b, external_irq_pin_a};
  assign pin_bus.mode = {`ISV_EDGE_BOTH, ctrl_q[`ISV_CTL_EDB_LO+:2], ctrl_q[`ISV_CTL_EDA_LO+:2]};

  isv_pin_edge #(.N(3)) u_pins (
    .hclk(hclk),
    .hresetn(hresetn),
    .pins(pin_bus.det)
  );

  // ****************************************************************
  // request sources feeding the table entries
  // ****************************************************************
  logic [31:0] src_set;
  always_comb begin
    src_set = periph_req;
    src_set[`ISV_REQ_PIN_A] = periph_req[`ISV_REQ_PIN_A] | pin_bus.hit[0];
    src_set[`ISV_REQ_PIN_B] = periph_req[`ISV_REQ_PIN_B] | pin_bus.hit[1];
    src_set[`ISV_REQ_VSYNC] = periph_req[`ISV_REQ_VSYNC] | pin_bus.hit[2];
    src_set[`ISV_REQ_I2C0] = periph_req[`ISV_REQ_I2C0] | i2c0_event;
    src_set[`ISV_REQ_I2C1] = periph_req[`ISV_REQ_I2C1] | i2c1_event;
    src_set[`ISV_REQ_DISP_A] = periph_req[`ISV_REQ_DISP_A] | display_done_irq_a;
    src_set[`ISV_REQ_DISP_B] = periph_req[`ISV_REQ_DISP_B] | display_done_irq_b;
  end

  // ****************************************************************
  // instruction and special events
  // ****************************************************************
  wire retire = insn_done;
  wire ev_und = retire & (insn_kind == ISV_INSN_UND);
  wire ev_ovf = retire & (insn_kind == ISV_INSN_INTO) & ovf_q;
  wire ev_brk = retire & (insn_kind == ISV_INSN_BRK);
  wire ev_swi = retire & (insn_kind == ISV_INSN_INT);
  wire ev_step = retire & ctrl_q[`ISV_CTL_DSTEP];
  // the core presents only instruction start addresses here
  wire ev_am = fetch_valid & ctrl_q[`ISV_CTL_AMEN] & (fetch_addr == amatch_q);
  wire [7:0] pend_set = {ev_am, ev_step, debugger_break_interrupt, wdt_req,
                         ev_swi, ev_brk, ev_ovf, ev_und};

  // ****************************************************************
  // selection: specials, then instruction traps, then peripherals
  // ****************************************************************
  // peripheral requests pass only with enable set and level above ipl
  wire mask_open = gie & (level_q > ipl);
  wire [31:0] req_live = mask_open ? req_q : 32'h0000_0000;

  // lowest numbered live request wins; full level arbitration is outside
  function automatic logic [5:0] isv_first(input logic [31:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction : isv_first

  // specials and traps never look at the enable or level
  wire any_pend = |pend_q;
  wire any_req = |req_live;
  wire can_take = (state_q == ISV_ST_IDLE) & ~bvalid_q;
  wire take = can_take & (any_pend | any_req);

  isv_cause_t pick_cause;
  logic [19:0] pick_vec;
  logic [5:0] pick_num;
  logic [7:0] pend_clr;
  always_comb begin
    pick_cause = ISV_C_PERIPH;
    pick_num = isv_first(req_live);
    pick_vec = tbase_q + {12'h000, pick_num, 2'b00};
    pend_clr = 8'h00;
    if (pend_q[`ISV_P_DBC]) begin
      pick_cause = ISV_C_DBC;
      pick_vec = `ISV_VEC_DBC;
      pend_clr[`ISV_P_DBC] = 1'b1;
    end else if (pend_q[`ISV_P_WDT]) begin
      pick_cause = ISV_C_WDT;
      pick_vec = `ISV_VEC_WDT;
      pend_clr[`ISV_P_WDT] = 1'b1;
    end else if (pend_q[`ISV_P_STEP]) begin
      pick_cause = ISV_C_STEP;
      pick_vec = `ISV_VEC_STEP;
      pend_clr[`ISV_P_STEP] = 1'b1;
    end else if (pend_q[`ISV_P_AM]) begin
      pick_cause = ISV_C_AMATCH;
      pick_vec = `ISV_VEC_AMATCH;
      pend_clr[`ISV_P_AM] = 1'b1;
    end else if (pend_q[`ISV_P_UND]) begin
      pick_cause = ISV_C_UND;
      pick_vec = `ISV_VEC_UND;
      pend_clr[`ISV_P_UND] = 1'b1;
    end else if (pend_q[`ISV_P_OVF]) begin
      pick_cause = ISV_C_OVF;
      pick_vec = `ISV_VEC_OVF;
      pend_clr[`ISV_P_OVF] = 1'b1;
    end else if (pend_q[`ISV_P_BRK]) begin
      pick_cause = ISV_C_BRK;
      pick_vec = `ISV_VEC_BRK;
      pend_clr[`ISV_P_BRK] = 1'b1;
    end else if (pend_q[`ISV_P_SWI]) begin
      pick_cause = ISV_C_SWI;
      pick_num = swi_num_q;
      pick_vec = tbase_q + {12'h000, swi_num_q, 2'b00};
      pend_clr[`ISV_P_SWI] = 1'b1;
    end
  end

  // table numbers below 32 switch to the interrupt stack pointer
  wire low_num = (pick_cause == ISV_C_PERIPH) |
                 ((pick_cause == ISV_C_SWI) & (swi_num_q < `ISV_SWI_SPLIT));

  // ****************************************************************
  // vector fetch and branch
  // ****************************************************************
  wire got = (state_q == ISV_ST_FETCH) & vec_rd_valid;
  // an erased breakpoint entry sends the read to table entry zero
  wire brk_fall = got & (cause_q == ISV_C_BRK) & ~brk_fb_q &
                  (vec_rd_data == `ISV_VEC_ERASED);
  wire done = got & ~brk_fall;

  assign vec_rd_req = (state_q == ISV_ST_FETCH);
  assign vec_rd_addr = vaddr_q;
  assign branch_valid = bvalid_q;
  assign branch_addr = baddr_q;
  assign irq_busy = (state_q == ISV_ST_FETCH) | bvalid_q;
  assign stack_select = ustk_q;

  // request bits: set wins over any clear in the same cycle
  wire [31:0] accept_clr = (take & (pick_cause == ISV_C_PERIPH)) ?
                           (32'h0000_0001 << pick_num[4:0]) : 32'h0000_0000;
  wire [31:0] sw_keep = wr_req ? hwdata : 32'hffff_ffff;
  wire [31:0] req_d = (req_q & sw_keep & ~accept_clr) | src_set;

  // ****************************************************************
  // bus-side registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_q <= 1'b0;
      dph_ofs_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      dph_wr_q <= ap_ok & hwrite;
      dph_ofs_q <= ap_ofs;
      if (ap_ok & ~hwrite) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // software configuration; stack select and overflow live elsewhere
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `ISV_CTL_RST;
      tbase_q <= `ISV_TBASE_RST;
      amatch_q <= 20'h00000;
      level_q <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= hwdata;
      end
      if (wr_tbase) begin
        tbase_q <= hwdata[19:0];
      end
      if (wr_amatch) begin
        amatch_q <= hwdata[19:0];
      end
      if (wr_level) begin
        level_q <= hwdata[2:0];
      end
    end
  end

  // ****************************************************************
  // flags, requests and pending events
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_q <= 1'b0;
      ustk_q <= 1'b0;
      usave_q <= 1'b0;
      req_q <= 32'h0000_0000;
      pend_q <= 8'h00;
      swi_num_q <= 6'h00;
    end else begin
      req_q <= req_d;
      // a new event wins over the clear of its own flag
      pend_q <= (pend_q & ~(take ? pend_clr : 8'h00)) | pend_set;
      if (ev_swi) begin
        swi_num_q <= insn_operand;
      end
      if (retire & (insn_kind == ISV_INSN_ARITH)) begin
        ovf_q <= arith_ovf;
      end
      if (take & low_num) begin
        usave_q <= ustk_q;
        ustk_q <= 1'b0;
      end else if (retire & (insn_kind == ISV_INSN_RETI)) begin
        ustk_q <= usave_q;
      end else if (wr_ctrl) begin
        ustk_q <= hwdata[`ISV_CTL_USTK];
      end
    end
  end

  // ****************************************************************
  // sequencer: reset starts with the reset vector read
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ISV_ST_FETCH;
      cause_q <= ISV_C_RESET;
      vaddr_q <= `ISV_VEC_RESET;
      num_q <= 6'h00;
      brk_fb_q <= 1'b0;
      bvalid_q <= 1'b0;
      baddr_q <= 20'h00000;
      stat_q <= 32'h0000_0000;
    end else begin
      bvalid_q <= done;
      unique case (state_q)
        ISV_ST_IDLE: begin
          if (take) begin
            state_q <= ISV_ST_FETCH;
            cause_q <= pick_cause;
            vaddr_q <= pick_vec;
            num_q <= pick_num;
            brk_fb_q <= 1'b0;
          end
        end
        ISV_ST_FETCH: begin
          if (brk_fall) begin
            vaddr_q <= tbase_q;
            brk_fb_q <= 1'b1;
          end else if (done) begin
            state_q <= ISV_ST_IDLE;
            baddr_q <= vec_rd_data[19:0];
            stat_q <= {2'b00, cause_q, num_q, vec_rd_data[19:0]};
          end
        end
      endcase
    end
  end
endmodule : isv_top

// ---- isv_chk_sva.sv ----
// isv_chk_sva.sv: assertions on the vector fetch ports of isv_top.
// assumes: bound to isv_top, one clock domain hclk.
`timescale 1ns/100ps
module isv_chk_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic wdt_req,
  input wire logic debugger_break_interrupt,
  input wire logic vec_rd_req,
  input wire logic [19:0] vec_rd_addr,
  input wire logic vec_rd_valid,
  input wire logic [31:0] vec_rd_data,
  input wire logic branch_valid,
  input wire logic [19:0] branch_addr,
  input wire logic irq_busy
);
  // ****
  // fetch and branch checks
  // ****
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // erased breakpoint entry must never become a target
  wire erased = vec_rd_addr == 20'hfffe4 && vec_rd_data == 32'hffffffff;
  wire [19:0] ent_addr = vec_rd_data[19:0]; // address part of an entry
  a_reset_entry:
    assert property ($rose(hresetn) |-> vec_rd_req && vec_rd_addr == 20'hffffc) else $error("reset fetch misplaced");
  a_branch_data:
    assert property (vec_rd_valid && !erased |=> branch_valid && branch_addr == $past(ent_addr))
      else $error("branch differs from entry");
  a_erased_skip:
    assert property (vec_rd_valid && erased |=> !branch_valid) else $error("branched to erased entry");
  a_busy_covers:
    assert property (branch_valid |-> irq_busy && !vec_rd_req) else $error("fetch still open at branch");
  a_addr_held:
    assert property (vec_rd_req && !vec_rd_valid |=> $stable(vec_rd_addr)) else $error("entry address moved");
  a_entry_align:
    assert property (vec_rd_req |-> vec_rd_addr[1:0] == 2'h0) else $error("entry not word aligned");
  a_branch_pulse:
    assert property (branch_valid |=> !branch_valid) else $error("branch pulse too long");
  a_dbc_entry:
    assert property (debugger_break_interrupt && !irq_busy |-> ##[1:2] (vec_rd_req && vec_rd_addr == 20'hffff4))
      else $error("debugger break entry wrong");
  a_wdt_entry:
    assert property (wdt_req && !debugger_break_interrupt && !irq_busy |-> ##[1:2] (vec_rd_req && vec_rd_addr == 20'hffff0))
      else $error("watchdog entry wrong");
endmodule : isv_chk_sva
bind isv_top isv_chk_sva i_isv_chk_sva (.hclk, .hresetn, .wdt_req, .debugger_break_interrupt, .vec_rd_req,
  .vec_rd_addr, .vec_rd_valid, .vec_rd_data, .branch_valid, .branch_addr, .irq_busy);

// ---- isv_mem_model.sv ----
// isv_mem_model.sv: vector memory as seen by the block's fetch port.
// assumes: one request at a time, address held until answered.
`timescale 1ns/100ps
module isv_mem_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [2:0] lat, // answer delay in cycles
  input wire logic erase_brk, // breakpoint entry reads as all ones
  input wire logic vec_rd_req,
  input wire logic [19:0] vec_rd_addr,
  output logic vec_rd_valid,
  output logic [31:0] vec_rd_data
);
  logic [2:0] wait_q; // cycles spent on the current request
  logic [31:0] word; // entry content at the requested address
  // entries hold a scrambled copy of their own address
  assign word = (erase_brk && vec_rd_addr == 20'hfffe4) ? 32'hffffffff : {12'ha5c, vec_rd_addr ^ 20'h3c3c3};
  // off the answer cycle the lines show the inverse, so stale data never passes
  assign vec_rd_data = vec_rd_valid ? word : ~word;
  // ****
  // answer after lat cycles, one-cycle pulse
  // ****
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_q <= 3'h0;
      vec_rd_valid <= 1'h0;
    end else if (vec_rd_req && !vec_rd_valid && wait_q >= lat) begin
      vec_rd_valid <= 1'h1;
      wait_q <= 3'h0;
    end else begin
      vec_rd_valid <= 1'h0;
      wait_q <= (vec_rd_req && !vec_rd_valid) ? wait_q + 3'h1 : 3'h0;
    end
  end
endmodule : isv_mem_model

// ---- tb_top.sv ----
// tb_top.sv: self-checking bench for isv_top with a vector memory model.
// assumes: isv_defs.svh on the include path.
`timescale 1ns/100ps
module tb_top;
  import isv_pkg::*;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, hready, hreadyout, hresp;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, periph_req = '0, vec_rd_data;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, lat = 3'h3;
  isv_insn_t insn_kind = ISV_INSN_NONE;
  logic [5:0] insn_operand = '0;
  logic insn_done = 1'h0, arith_ovf = 1'h0, fetch_valid = 1'h0, wdt_req = 1'h0, debugger_break_interrupt = 1'h0;
  logic external_irq_pin_a = 1'h0, external_irq_pin_b = 1'h0, vsync_pin = 1'h0, erase = 1'h0;
  logic display_done_irq_a = 1'h0, display_done_irq_b = 1'h0, i2c0_event = 1'h0, i2c1_event = 1'h0;
  logic [19:0] fetch_addr = '0, vec_rd_addr, branch_addr, tbase, am;
  logic vec_rd_req, vec_rd_valid, branch_valid, irq_busy, stack_select;
  int errors = 0, check_count = 0;
  logic [19:0] exp_q[$]; // expected branch targets, oldest first
  assign hready = hreadyout; // single slave drives the bus ready
  always #5 hclk = ~hclk;
  isv_top i_isv_top (.*);
  isv_mem_model i_isv_mem_model (.hclk(hclk), .hresetn(hresetn), .lat(lat), .erase_brk(erase),
    .vec_rd_req(vec_rd_req), .vec_rd_addr(vec_rd_addr), .vec_rd_valid(vec_rd_valid), .vec_rd_data(vec_rd_data));
  // ****
  // helpers
  // ****
  function automatic logic [19:0] ent(input logic [19:0] a);
    return a ^ 20'h3c3c3; // same scramble as the memory model
  endfunction : ent
  task automatic test_done();
    if (errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // bounded wait for hready; a hang ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'h1 && n < 50);
    if (n >= 50) begin
      errors++;
      test_done();
    end
  endtask : wait_rdy
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'h1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'h0, a, 32'h0, r);
    chk(r ^ {hresp, 31'h0}, e);
  endtask : rd
  // let every noted branch land, then leave room for a stray one
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 300) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 300) begin
      errors++;
      test_done();
    end
    repeat (12) @(posedge hclk);
  endtask : drain
  task automatic insn(input isv_insn_t k, input logic [5:0] op, input logic ov);
    insn_kind <= k;
    insn_operand <= op;
    arith_ovf <= ov;
    insn_done <= 1'h1;
    @(posedge hclk);
    insn_done <= 1'h0;
    @(posedge hclk);
  endtask : insn
  // every branch must match the oldest note; an unexpected one never matches
  always @(posedge hclk) begin
    if (hresetn && branch_valid === 1'h1) begin
      if (exp_q.size() == 0)
        chk({12'h0, branch_addr}, 32'hffffffff);
      else
        chk({12'h0, branch_addr}, {12'h0, exp_q.pop_front()});
    end
  end
  // ****
  // scenarios
  // ****
  initial begin
    int unsigned s;
    logic [5:0] n;
    s = $urandom(32'hc9a9702a);
    exp_q.push_back(ent(20'hffffc));
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    drain();
    rd(8'h40, 32'h0);
    tbase = 20'($urandom) & 20'hfff00;
    lat <= 3'($urandom % 6);
    wr(8'h04, {12'h0, tbase});
    exp_q.push_back(ent(20'hfffdc));
    insn(ISV_INSN_UND, 6'h0, 1'h0);
    drain();
    insn(ISV_INSN_ARITH, 6'h0, 1'h1);
    exp_q.push_back(ent(20'hfffe0));
    insn(ISV_INSN_INTO, 6'h0, 1'h0);
    drain();
    insn(ISV_INSN_ARITH, 6'h0, 1'h0);
    insn(ISV_INSN_OTHER, 6'h0, 1'h1);
    insn(ISV_INSN_INTO, 6'h0, 1'h0);
    drain();
    exp_q.push_back(ent(20'hfffe4));
    insn(ISV_INSN_BRK, 6'h0, 1'h0);
    drain();
    erase <= 1'h1;
    exp_q.push_back(ent(tbase));
    insn(ISV_INSN_BRK, 6'h0, 1'h0);
    drain();
    exp_q.push_back(ent(20'hffff4));
    debugger_break_interrupt <= 1'h1;
    @(posedge hclk);
    debugger_break_interrupt <= 1'h0;
    drain();
    exp_q.push_back(ent(20'hffff0));
    wdt_req <= 1'h1;
    @(posedge hclk);
    wdt_req <= 1'h0;
    drain();
    // low and high software numbers, stack select preset to 1
    for (int i = 0; i < 2; i++) begin
      n = 6'(i * 32 + $urandom % 32);
      wr(8'h00, 32'h40);
      exp_q.push_back(ent(tbase + {12'h0, n, 2'h0}));
      insn(ISV_INSN_INT, n, 1'h0);
      drain();
      chk({31'h0, stack_select}, {31'h0, n[5]});
      insn(ISV_INSN_RETI, 6'h0, 1'h0);
      @(posedge hclk);
      chk({31'h0, stack_select}, 32'h1);
    end
    wr(8'h00, 32'h10);
    exp_q.push_back(ent(20'hfffec));
    insn(ISV_INSN_OTHER, 6'h0, 1'h0);
    drain();
    am = 20'($urandom);
    wr(8'h08, {12'h0, am});
    wr(8'h00, 32'h20);
    // second byte first: no hit; then the first byte
    for (int j = 0; j < 2; j++) begin
      if (j == 1) exp_q.push_back(ent(20'hfffe8));
      fetch_addr <= am + 20'(1 - j);
      fetch_valid <= 1'h1;
      @(posedge hclk);
      fetch_valid <= 1'h0;
      drain();
    end
    wr(8'h00, 32'h900);
    {external_irq_pin_a, external_irq_pin_b, vsync_pin} <= 3'h7;
    {display_done_irq_a, display_done_irq_b, i2c0_event, i2c1_event} <= 4'hf;
    @(posedge hclk);
    {display_done_irq_a, display_done_irq_b, i2c0_event, i2c1_event} <= 4'h0;
    repeat (6) @(posedge hclk);
    rd(8'h0c, 32'h20102310);
    wr(8'h0c, 32'h0);
    {external_irq_pin_a, external_irq_pin_b, vsync_pin} <= 3'h0;
    repeat (6) @(posedge hclk);
    rd(8'h0c, 32'h40100000);
    wr(8'h0c, 32'hffffffff);
    rd(8'h0c, 32'h40100000);
    wr(8'h0c, 32'h0);
    n = 6'($urandom % 32);
    periph_req <= 32'h1 << n;
    @(posedge hclk);
    periph_req <= 32'h0;
    rd(8'h0c, 32'h1 << n);
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h3);
    drain();
    exp_q.push_back(ent(tbase + {12'h0, n, 2'h0}));
    wr(8'h00, 32'h1);
    drain();
    rd(8'h0c, 32'h0);
    test_done();
  end
endmodule : tb_top
